// file: src/dcs_setup_regs.sv
// Two-channel transfer setup registers with Wishbone slave and interrupt
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "dcs_defines.svh"
module dcs_setup_regs
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Mover side, per channel
   input wire logic [1:0] xfer_step,
   input wire logic [1:0] xfer_err,
   output logic [1:0] xfer_run,
   output logic [37:0] xfer_src,
   output logic [37:0] xfer_dst,
   output logic [35:0] xfer_len,
   output logic [7:0] xfer_src_sel,
   output logic [7:0] xfer_dst_sel,
   output logic [3:0] xfer_sample_size,
   output logic [3:0] xfer_unit,
   // Interrupt
   output logic irq
);
   logic [12:0] ctl_ff [`DCS_NCH];
   logic [18:0] src_ff [`DCS_NCH];
   logic [18:0] dst_ff [`DCS_NCH];
   logic [17:0] len_ff [`DCS_NCH];
   logic [1:0] stat_ff;
   logic [1:0] mask_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic irq_ff;
   logic [1:0] done_ev;
   logic [1:0] clr_go;
   logic [1:0] run_w;
   dcs_xfer_type prog [`DCS_NCH];
   dcs_xfer_type act [`DCS_NCH];
   logic req;
   logic wr;
   logic [31:0] wmask;
   logic [31:0] rd_mux;
   logic [1:0] stat_clr;

   assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
   // Writes act at the edge that ends the ack cycle, while the master still holds
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   genvar g;
   generate
      for (g = 0; g < `DCS_NCH; g++) begin : g_ch
         logic [7:0] base;
         logic [3:0] ssel;
         logic [3:0] dsel;
         logic wide;
         logic [18:0] amask;
         logic fifo_wr;
         logic fifo_rd;
         logic [31:0] wd;
         logic [1:0] r_run;
         logic [3:0] sz;
         assign base = 8'(`DCS_OFS_CH0_CTL + g * 16);
         assign wd = wb_dat_i & wmask;
         assign ssel = ctl_ff[g][`DCS_SRC_HI:`DCS_SRC_LO];
         assign dsel = ctl_ff[g][`DCS_DST_HI:`DCS_DST_LO];
         assign wide = ctl_ff[g][`DCS_BIT_WIDTH];
         // Width-dependent address bit masking
         always_comb begin
            amask = '1;
            if ((dsel == `DCS_DST_I2S_DAC || ssel == `DCS_SRC_I2S) && !wide)
               amask[`DCS_ADDR_BIT_HALF] = 1'b0;
            if ((dsel == `DCS_SEL_SPI1 || ssel == `DCS_SEL_SPI1) && wide)
               amask[`DCS_ADDR_BIT_WORD] = 1'b0;
         end
         // Length unit selection
         assign fifo_wr = dsel == `DCS_DST_LCD || dsel == `DCS_DST_I2S_DAC ||
            dsel == `DCS_SEL_SPI0 || dsel == `DCS_SEL_SPI1 ||
            dsel == `DCS_DST_MODEM;
         assign fifo_rd = ssel == `DCS_SRC_ADC || ssel == `DCS_SEL_SPI0 ||
            ssel == `DCS_SEL_SPI1 || ssel == `DCS_SRC_MODEM;
         always_comb begin
            prog[g].src = src_ff[g] & amask;
            prog[g].dst = dst_ff[g] & amask;
            prog[g].len = len_ff[g];
            prog[g].src_sel = ssel;
            prog[g].dst_sel = dsel;
            prog[g].wide = wide;
            if (fifo_wr)
               prog[g].unit = `DCS_UNIT_FIFO_WR;
            else if (fifo_rd)
               prog[g].unit = `DCS_UNIT_FIFO_RD;
            else
               prog[g].unit = `DCS_UNIT_BYTE;
         end
         // Sample size in bytes from the width bit and selectors
         always_comb begin
            sz = 4'h1;
            if (act[g].dst_sel == `DCS_DST_I2S_DAC ||
                act[g].src_sel == `DCS_SRC_I2S)
               sz = act[g].wide ? 4'h3 : 4'h2;
            else if (act[g].dst_sel == `DCS_SEL_SPI1 ||
                     act[g].src_sel == `DCS_SEL_SPI1)
               sz = act[g].wide ? 4'h4 : 4'h1;
         end
         dcs_chan_ctl u_ctl (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .prog(prog[g]),
            .go_bit(ctl_ff[g][`DCS_BIT_GO]),
            .reload(ctl_ff[g][`DCS_BIT_RELOAD]),
            .step(xfer_step[g]),
            .xfer_err(xfer_err[g]),
            .active(act[g]),
            .running(run_w[g]),
            .done_pulse(done_ev[g]),
            .clear_go(clr_go[g]),
            .remain()
         );
         // Register writes
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               ctl_ff[g] <= '0;
               src_ff[g] <= '0;
               dst_ff[g] <= '0;
               len_ff[g] <= '0;
            end else if (clk_en) begin
               if (wr && wb_adr_i == base) begin
                  ctl_ff[g] <= (ctl_ff[g] & ~wmask[12:0]) |
                     (wd[12:0] & `DCS_CTL_WMASK);
               end else if (clr_go[g]) begin
                  ctl_ff[g][`DCS_BIT_GO] <= 1'b0;
               end
               if (wr && wb_adr_i == 8'(base + 8'h04))
                  src_ff[g] <= (src_ff[g] & ~wmask[18:0]) |
                     wd[18:0];
               if (wr && wb_adr_i == 8'(base + 8'h08))
                  dst_ff[g] <= (dst_ff[g] & ~wmask[18:0]) |
                     wd[18:0];
               if (wr && wb_adr_i == 8'(base + 8'h0c))
                  len_ff[g] <= (len_ff[g] & ~wmask[17:0]) | wd[17:0];
            end
         end
         // Latched parameters to the mover
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               xfer_src[g*19 +: 19] <= '0;
               xfer_dst[g*19 +: 19] <= '0;
               xfer_len[g*18 +: 18] <= '0;
               xfer_src_sel[g*4 +: 4] <= '0;
               xfer_dst_sel[g*4 +: 4] <= '0;
               xfer_sample_size[g*2 +: 2] <= '0;
               xfer_unit[g*2 +: 2] <= '0;
               xfer_run[g] <= 1'b0;
            end else if (clk_en) begin
               xfer_src[g*19 +: 19] <= act[g].src;
               xfer_dst[g*19 +: 19] <= act[g].dst;
               xfer_len[g*18 +: 18] <= act[g].len;
               xfer_src_sel[g*4 +: 4] <= act[g].src_sel;
               xfer_dst_sel[g*4 +: 4] <= act[g].dst_sel;
               xfer_sample_size[g*2 +: 2] <= 2'(sz - 4'h1);
               xfer_unit[g*2 +: 2] <= act[g].unit;
               xfer_run[g] <= run_w[g];
            end
         end
      end
   endgenerate

   // Read multiplexer
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (wb_adr_i)
         `DCS_OFS_INT_STATUS: rd_mux = {30'h0, stat_ff};
         `DCS_OFS_INT_MASK: rd_mux = {30'h0, mask_ff};
         `DCS_OFS_CH0_CTL: rd_mux = {19'h0, ctl_ff[0]};
         `DCS_OFS_CH0_SRC: rd_mux = {13'h0, src_ff[0]};
         `DCS_OFS_CH0_DST: rd_mux = {13'h0, dst_ff[0]};
         `DCS_OFS_CH0_LEN: rd_mux = {14'h0, len_ff[0]};
         `DCS_OFS_CH1_CTL: rd_mux = {19'h0, ctl_ff[1]};
         `DCS_OFS_CH1_SRC: rd_mux = {13'h0, src_ff[1]};
         `DCS_OFS_CH1_DST: rd_mux = {13'h0, dst_ff[1]};
         `DCS_OFS_CH1_LEN: rd_mux = {14'h0, len_ff[1]};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Bus answer one cycle after request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else if (clk_en) begin
         ack_ff <= req;
         if (req)
            rdat_ff <= rd_mux;
      end
   end

   assign stat_clr = (wr && wb_adr_i == `DCS_OFS_INT_STATUS) ?
      (wb_dat_i[1:0] & {2{wb_sel_i[0]}}) : 2'b00;

   // Interrupt status, mask and output
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_ff <= 2'b00;
         mask_ff <= 2'b00;
         irq_ff <= 1'b0;
      end else if (clk_en) begin
         stat_ff <= (stat_ff & ~stat_clr) | done_ev;
         if (wr && wb_adr_i == `DCS_OFS_INT_MASK && wb_sel_i[0])
            mask_ff <= wb_dat_i[1:0];
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign irq = irq_ff;
endmodule // dcs_setup_regs

// file: src/dcs_defines.svh
// Register offsets, field positions and selector codes for the channel setup block
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
`define DCS_OFS_INT_STATUS 8'h00
`define DCS_OFS_INT_MASK 8'h04
`define DCS_OFS_CH0_CTL 8'h10
`define DCS_OFS_CH0_SRC 8'h14
`define DCS_OFS_CH0_DST 8'h18
`define DCS_OFS_CH0_LEN 8'h1c
`define DCS_OFS_CH1_CTL 8'h20
`define DCS_OFS_CH1_SRC 8'h24
`define DCS_OFS_CH1_DST 8'h28
`define DCS_OFS_CH1_LEN 8'h2c
`define DCS_ADDR_W 19
`define DCS_LEN_W 18
`define DCS_CTL_W 13
`define DCS_BIT_GO 0
`define DCS_BIT_RELOAD 1
`define DCS_SRC_LO 4
`define DCS_SRC_HI 7
`define DCS_DST_LO 8
`define DCS_DST_HI 11
`define DCS_BIT_WIDTH 12
`define DCS_CTL_WMASK 13'h1ff3
`define DCS_ADDR_BIT_HALF 0
`define DCS_ADDR_BIT_WORD 10
`define DCS_NCH 2
`define DCS_SEL_MEM 4'h0
`define DCS_SEL_BBRAM 4'h1
`define DCS_DST_MODEM 4'h2
`define DCS_DST_UART0 4'h3
`define DCS_DST_I2S_DAC 4'h5
`define DCS_SEL_SD 4'h6
`define DCS_SEL_SD1 4'h7
`define DCS_SEL_UART1 4'h8
`define DCS_SEL_SPI1 4'h9
`define DCS_DST_LCD 4'hc
`define DCS_SEL_SPI0 4'hd
`define DCS_SRC_UART0 4'h3
`define DCS_SRC_MODEM 4'h4
`define DCS_SRC_ADC 4'h5
`define DCS_SRC_I2S 4'ha
`define DCS_UNIT_BYTE 2'h0
`define DCS_UNIT_FIFO_WR 2'h1
`define DCS_UNIT_FIFO_RD 2'h2
`endif

// file: src/dcs_pkg.sv
// Types shared by the channel setup block
package dcs_pkg;
   typedef enum logic [1:0] {
      DCS_IDLE = 2'b00,
      DCS_RUN = 2'b01,
      DCS_DONE = 2'b11
   } dcs_state_type;

   typedef struct packed {
      logic [18:0] src;
      logic [18:0] dst;
      logic [17:0] len;
      logic [3:0] src_sel;
      logic [3:0] dst_sel;
      logic wide;
      logic [1:0] unit;
   } dcs_xfer_type;
endpackage

// file: src/dcs_chan_ctl.sv
// One channel's run control: latch, count, complete, abort, reload
`timescale 1ns/1ps
`include "dcs_defines.svh"
module dcs_chan_ctl
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Programmed parameters
   input wire dcs_xfer_type prog,
   input wire logic go_bit,
   input wire logic reload,
   // Mover side
   input wire logic step,
   input wire logic xfer_err,
   // Results
   output dcs_xfer_type active,
   output logic running,
   output logic done_pulse,
   output logic clear_go,
   output logic [17:0] remain
);
   dcs_state_type state_ff;
   dcs_state_type nxt_state;
   logic go_prev_ff;
   logic [17:0] cnt_ff;
   logic [17:0] nxt_cnt;
   logic done_ff;
   logic clr_ff;
   dcs_xfer_type act_ff;
   logic rise;
   logic last;

   assign rise = go_bit & ~go_prev_ff;
   assign last = step & (cnt_ff <= 18'h00001);
   assign active = act_ff;
   assign running = (state_ff == DCS_RUN);
   assign done_pulse = done_ff;
   assign clear_go = clr_ff;
   assign remain = cnt_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         DCS_IDLE: begin
            if (rise) begin
               nxt_state = DCS_RUN;
               nxt_cnt = prog.len;
            end
         end
         DCS_RUN: begin
            if (!go_bit || xfer_err) begin
               nxt_state = DCS_IDLE;
            end else if (last || cnt_ff == 18'h00000) begin
               nxt_state = DCS_DONE;
            end else if (step) begin
               nxt_cnt = cnt_ff - 18'h00001;
            end
         end
         DCS_DONE: begin
            if (reload && go_bit) begin
               nxt_state = DCS_RUN;
               nxt_cnt = prog.len;
            end else begin
               nxt_state = DCS_IDLE;
            end
         end
         default: nxt_state = DCS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= DCS_IDLE;
         cnt_ff <= 18'h00000;
         go_prev_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         go_prev_ff <= go_bit;
      end
   end

   // Parameters frozen while running
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_ff <= '0;
      end else if (clk_en) begin
         if ((state_ff == DCS_IDLE && rise) ||
             (state_ff == DCS_DONE && reload && go_bit)) begin
            act_ff <= prog;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_ff <= 1'b0;
         clr_ff <= 1'b0;
      end else if (clk_en) begin
         done_ff <= (state_ff == DCS_RUN) && (nxt_state == DCS_DONE);
         clr_ff <= ((state_ff == DCS_RUN) && go_bit && xfer_err) ||
            ((state_ff == DCS_DONE) && !(reload && go_bit));
      end
   end
endmodule // dcs_chan_ctl

// file: tb/dcs_setup_regs_sva.sv
// Concurrent checks on the channel setup block ports
`timescale 1ns/1ps
module dcs_setup_regs_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Mover side
   input wire logic [1:0] xfer_err,
   input wire logic [1:0] xfer_run,
   input wire logic [37:0] xfer_src,
   input wire logic [37:0] xfer_dst,
   input wire logic [35:0] xfer_len,
   input wire logic [7:0] xfer_src_sel,
   input wire logic [7:0] xfer_dst_sel,
   input wire logic [3:0] xfer_sample_size,
   input wire logic [3:0] xfer_unit,
   // Interrupt
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en
      |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("request not answered");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   property p_err_stop; xfer_run[0] && xfer_err[0] |-> ##[1:3] !xfer_run[0];
   endproperty
   a_err_stop: assert property (p_err_stop)
      else $error("error did not stop channel");
   property p_hold; xfer_run[0] && $past(xfer_run[0]) |->
      $stable({xfer_src[18:0], xfer_dst[18:0], xfer_len[17:0]}); endproperty
   a_hold: assert property (p_hold)
      else $error("latched values moved while running");
   property p_half; xfer_run[0] && xfer_dst_sel[3:0] == 4'h5 &&
      xfer_sample_size[1:0] == 2'h1 |-> !xfer_src[0] && !xfer_dst[0];
   endproperty
   a_half: assert property (p_half)
      else $error("bit zero not ignored");
   property p_word; xfer_run[0] && xfer_dst_sel[3:0] == 4'h9 &&
      xfer_sample_size[1:0] == 2'h3 |-> !xfer_src[10] && !xfer_dst[10];
   endproperty
   a_word: assert property (p_word)
      else $error("bit ten not ignored");
   property p_fifo_wr; xfer_run[0] && xfer_src_sel[3:0] == 4'h0 &&
      xfer_dst_sel[3:0] == 4'hc |-> xfer_unit[1:0] == 2'h1; endproperty
   a_fifo_wr: assert property (p_fifo_wr)
      else $error("display target not counted in writes");
   property p_fifo_rd; xfer_run[0] && xfer_dst_sel[3:0] == 4'h0 &&
      xfer_src_sel[3:0] == 4'h5 |-> xfer_unit[1:0] == 2'h2; endproperty
   a_fifo_rd: assert property (p_fifo_rd)
      else $error("converter source not counted in reads");
   property p_bytes; xfer_run[0] && xfer_src_sel[3:0] == 4'h0 &&
      xfer_dst_sel[3:0] == 4'h0 |-> xfer_unit[1:0] == 2'h0; endproperty
   a_bytes: assert property (p_bytes)
      else $error("memory copy not counted in bytes");
   c_done: cover property (xfer_run[0] ##1 !xfer_run[0]);
   c_irq: cover property (irq);
   c_err: cover property (xfer_run[0] && xfer_err[0]);
endmodule // dcs_setup_regs_sva
bind dcs_setup_regs dcs_setup_regs_sva dcs_setup_regs_sva_i (.core_clk,
   .rst_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .xfer_err, .xfer_run,
   .xfer_src, .xfer_dst, .xfer_len, .xfer_src_sel, .xfer_dst_sel,
   .xfer_sample_size, .xfer_unit, .irq);

// file: tb/dcs_mover_model.sv
// Behavioural mover that consumes units while a channel runs
`timescale 1ns/1ps
module dcs_mover_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bench control
   input wire logic slow,
   input wire logic [1:0] err_req,
   // Block side
   input wire logic [1:0] xfer_run,
   input wire logic [35:0] xfer_len,
   output logic [1:0] xfer_step,
   output logic [1:0] xfer_err
);
   logic [1:0] pace_ff;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) pace_ff <= 2'h0;
      else pace_ff <= (pace_ff == 2'h2) ? 2'h0 : pace_ff + 2'h1;
   end
   assign xfer_err = err_req & xfer_run;
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic seen_ff;
      logic step_ff;
      logic [17:0] left_ff;
      assign xfer_step[c] = step_ff;
      // Moves exactly the latched count
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            seen_ff <= 1'b0;
            step_ff <= 1'b0;
            left_ff <= 18'h0;
         end else begin
            seen_ff <= xfer_run[c];
            step_ff <= 1'b0;
            if (xfer_run[c] && !seen_ff) begin
               left_ff <= xfer_len[c*18 +: 18];
            end else if (xfer_run[c] && left_ff != 18'h0 && !step_ff &&
                  (!slow || pace_ff == 2'h0)) begin
               step_ff <= 1'b1;
               left_ff <= left_ff - 18'h1;
            end
         end
      end
   end
endmodule // dcs_mover_model

// file: tb/dcs_setup_regs_test.sv
// Self-checking bench for the channel setup block
`timescale 1ns/1ps
module dcs_setup_regs_test;
   logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, slow = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq;
   logic [7:0] wb_adr_i = 8'h0;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [1:0] xfer_step, xfer_err, xfer_run, err_req = 2'h0;
   logic [37:0] xfer_src, xfer_dst;
   logic [35:0] xfer_len;
   logic [7:0] xfer_src_sel, xfer_dst_sel;
   logic [3:0] xfer_sample_size, xfer_unit;
   int fails = 0, cmp_count = 0, steps = 0, cycles = 0;
   dcs_setup_regs dcs_setup_regs_i (.*);
   dcs_mover_model dcs_mover_model_i (.*);
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (xfer_run[0] === 1'b1 && xfer_step[0] === 1'b1) steps <= steps + 1;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic t_regs;
      logic [7:0] ofs [8] = '{8'h14, 8'h18, 8'h1c, 8'h24, 8'h28, 8'h2c,
         8'h20, 8'h30};
      logic [31:0] e [8] = '{32'h7fffe, 32'h7fffe, 32'h3fffe, 32'h7fffe,
         32'h7fffe, 32'h3fffe, 32'h1ff2, 32'h0};
      for (int i = 0; i < 8; i++) begin
         wb(ofs[i], 1'b0, 32'h0);
         check("reset value", 32'h0, q);
         wb(ofs[i], 1'b1, 32'hfffffffe);
         wb(ofs[i], 1'b0, 32'h0);
         check("read back", e[i], q);
      end
      wb_sel_i <= 4'h1;
      wb(8'h24, 1'b1, 32'h0);
      wb_sel_i <= 4'hf;
      wb(8'h24, 1'b0, 32'h0);
      check("byte lane", 32'h7ff00, q);
      $display("register test done");
   endtask
   function automatic logic [1:0] exp_unit(input logic [3:0] s, d);
      if (d inside {4'h2, 4'h5, 4'h9, 4'hc, 4'hd}) return 2'h1;
      if (s inside {4'h4, 4'h5, 4'h9, 4'hd}) return 2'h2;
      return 2'h0;
   endfunction
   task automatic t_run(input logic [3:0] s, d, input logic w);
      logic [31:0] m;
      m = 32'h7ffff;
      if (!w && (d == 4'h5 || s == 4'ha)) m[0] = 1'b0;
      if (w && (d == 4'h9 || s == 4'h9)) m[10] = 1'b0;
      wb(8'h04, 1'b1, {31'h0, w});
      wb(8'h14, 1'b1, 32'hffffffff);
      wb(8'h18, 1'b1, 32'hffffffff);
      wb(8'h1c, 1'b1, 32'h3);
      steps = 0;
      wb(8'h10, 1'b1, {19'h0, w, d, s, 4'h1});
      while (xfer_run[0] !== 1'b1) @(posedge core_clk);
      check("src", m, {13'h0, xfer_src[18:0]});
      check("dst", m, {13'h0, xfer_dst[18:0]});
      check("len", 32'h3, {14'h0, xfer_len[17:0]});
      check("sel", {24'h0, d, s}, {24'h0, xfer_dst_sel[3:0],
         xfer_src_sel[3:0]});
      check("unit", {30'h0, exp_unit(s, d)},
         {30'h0, xfer_unit[1:0]});
      if (d == 4'h5 || s == 4'ha)
         check("size", {30'h0, w, !w},
            {30'h0, xfer_sample_size[1:0]});
      if (d == 4'h9 || s == 4'h9)
         check("size", {30'h0, w, w},
            {30'h0, xfer_sample_size[1:0]});
      while (xfer_run[0] === 1'b1) @(posedge core_clk);
      check("steps", 32'h3, 32'(steps));
      repeat (2) @(posedge core_clk);
      check("irq", {31'h0, w}, {31'h0, irq});
      wb(8'h10, 1'b0, 32'h0);
      check("go", 32'h0, {31'h0, q[0]});
      wb(8'h00, 1'b0, 32'h0);
      check("status", 32'h1, q);
      wb(8'h00, 1'b1, 32'h1);
      wb(8'h00, 1'b0, 32'h0);
      check("status clear", 32'h0, q);
      check("irq clear", 32'h0, {31'h0, irq});
      $display("run %h %h %b done", s, d, w);
   endtask
   task automatic t_err;
      slow <= 1'b1;
      wb(8'h14, 1'b1, 32'h100);
      wb(8'h1c, 1'b1, 32'd100);
      wb(8'h10, 1'b1, 32'h1);
      while (xfer_run[0] !== 1'b1) @(posedge core_clk);
      wb(8'h14, 1'b1, 32'h200);
      check("held src", 32'h100, {13'h0, xfer_src[18:0]});
      err_req <= 2'h1;
      @(posedge core_clk);
      err_req <= 2'h0;
      repeat (4) @(posedge core_clk);
      check("err run", 32'h0, {31'h0, xfer_run[0]});
      wb(8'h10, 1'b0, 32'h0);
      check("err go", 32'h0, q);
      wb(8'h00, 1'b0, 32'h0);
      check("err status", 32'h0, q);
      wb(8'h1c, 1'b1, 32'h1);
      wb(8'h10, 1'b1, 32'h3);
      do wb(8'h00, 1'b0, 32'h0); while (q[0] !== 1'b1);
      wb(8'h10, 1'b0, 32'h0);
      check("reload go", 32'h3, q);
      wb(8'h10, 1'b1, 32'h0);
      repeat (4) @(posedge core_clk);
      check("abort run", 32'h0, {31'h0, xfer_run[0]});
      wb(8'h00, 1'b1, 32'h1);
      repeat (4) @(posedge core_clk);
      wb(8'h00, 1'b0, 32'h0);
      check("abort status", 32'h0, q);
      slow <= 1'b0;
      $display("error and abort test done");
   endtask
   task automatic t_ch1;
      wb(8'h24, 1'b1, 32'h123);
      wb(8'h2c, 1'b1, 32'h2);
      wb(8'h20, 1'b1, 32'hc51);
      while (xfer_run[1] !== 1'b1) @(posedge core_clk);
      check("ch1 src", 32'h123, {13'h0, xfer_src[37:19]});
      check("ch1 dst", 32'h7fffe, {13'h0, xfer_dst[37:19]});
      check("ch1 len", 32'h2, {14'h0, xfer_len[35:18]});
      check("ch1 sel", 32'hc5,
         {24'h0, xfer_dst_sel[7:4], xfer_src_sel[7:4]});
      check("ch1 unit", 32'h1, {30'h0, xfer_unit[3:2]});
      while (xfer_run[1] === 1'b1) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      wb(8'h00, 1'b0, 32'h0);
      check("ch1 status", 32'h2, q);
      wb(8'h20, 1'b0, 32'h0);
      check("ch1 go", 32'hc50, q);
      $display("channel one test done");
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      for (int k = 0; k < 32; k++) begin
         slow <= k[0];
         t_run(k[3:0], 4'h0, k[4]);
         t_run(4'h0, k[3:0], k[4]);
      end
      t_err();
      t_ch1();
      tally_and_finish();
   end
endmodule // dcs_setup_regs_test
